// *** hdl/apipc_top.sv ***
// Converter-pair interrupt priority controller with AXI4-Lite registers
// Functional notes
// R1 - 3-bit priority: 7 highest, 0 disables source
// R2 - All pair priorities reset to level four
// R3 - Register one: pair1 bits 14:12, pair0 10:8
// R4 - Register two: pairs 5,4,3,2 one per nibble
// R5 - Register three: pair6 in bits 2:0
// R6 - Unimplemented bits read zero, writes ignored
// R7 - Status bits 11:8 show CPU level
// R8 - Status bits 6:0 show pending vector minus eight
// R9 - Nesting disable bit 15 blocks nested interrupts
// R10 - Software: priority, clear flag, then enable
// R11 - Flag stays set; request retaken after return
// R12 - Return restores saved low byte and level
// R13 - Trap flag stays until software clears it
// R14 - Low byte OR E0 raises level to seven
// R15 - Traps at levels 8-15 never masked
// R16 - Timed disable blocks levels 1-6, not 7
// R17 - Taken only above CPU level; level follows source
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
module apipc_top #(
  parameter int PAIRS = apipc_pkg::PAIR_COUNT,
  parameter int TRAPS = apipc_pkg::TRAP_COUNT,
  parameter int DEPTH = apipc_pkg::STACK_DEPTH,
  parameter logic [6:0] USER_VEC_BASE = 7'h20
) (
  input wire logic mclk,
  input wire logic reset_n,
  // AXI4-Lite slave
  input wire logic [apipc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [apipc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Peripheral and trap events
  input wire logic [PAIRS-1:0] pairDoneEvent,
  input wire logic [TRAPS-1:0] trapEvent,
  // CPU core side
  input wire logic cpuTake,
  input wire logic cpuReturn,
  output logic irqRequest,
  output logic [6:0] irqVectorIndex,
  output logic [3:0] irqLevel,
  output logic [3:0] currentCpuLevel,
  output logic irqLine
);
  import apipc_pkg::*;

  localparam int SP_W = $clog2(DEPTH + 1);

  // ****************
  // State
  // ****************
  // Everything the block remembers lives in one record
  typedef struct packed {
    logic awReady;                       // Write address accepted when high
    logic wReady;                        // Write data accepted when high
    logic awGot;                         // Write address held
    logic wGot;                          // Write data held
    logic [ADDR_W-1:0] awAddr;           // Held write address
    logic [31:0] wData;                  // Held write data
    logic [3:0] wStrb;                   // Held byte strobes
    logic bValid;                        // Write response pending
    logic [1:0] bResp;                   // Write response code
    logic arReady;                       // Read address accepted when high
    logic rValid;                        // Read data pending
    logic [1:0] rResp;                   // Read response code
    logic [31:0] rData;                  // Read data
    logic [PAIRS-1:0][2:0] prio;         // Pair priorities
    logic [PAIRS-1:0] flags;             // Sticky done flags
    logic [PAIRS-1:0] enables;           // Source enables
    logic [TRAPS-1:0] trapFlags;         // Sticky trap flags
    logic nestDis;                       // Nesting disable
    logic [7:0] status_low_byte;                     // Status low byte, level in 7:5
    logic ipl3;                          // Level bit three, set in traps
    logic [TIMED_INTERRUPT_DISABLE_W-1:0] disiCount;        // Timed disable cycles left
    logic [DEPTH-1:0][8:0] stack;        // Saved {ipl3, srl}
    logic [SP_W-1:0] sp;                 // Stack fill
    logic irqRequest;                    // Offer to the CPU
    logic [6:0] vecIndex;                // Offered vector minus eight
    logic [3:0] offerLevel;              // Level of the offer
    logic irqLine;                       // Enabled flag summary
  } apipc_state_t;

  apipc_state_t stateReg;
  apipc_state_t stateNext;

  // Winner search outputs
  logic winValid;
  logic [3:0] winLevel;
  logic [6:0] winIndex;
  logic [3:0] curLevel;

  // ****************
  // Helpers
  // ****************
  // Assemble one priority register; absent bits stay zero
  function automatic logic [31:0] packPrio(input int idx, input logic [PAIRS-1:0][2:0] pr);
    logic [31:0] v;
    v = 32'h0000_0000;
    for (int p = 0; p < PAIRS; p++) begin
      if (PAIR_REG[p] == idx) begin
        v[PAIR_LSB[p] +: 3] = pr[p]; // see R3 see R4 see R5 see R6
      end
    end
    return v;
  endfunction

  // Register read decode
  function automatic logic [33:0] readWord(input logic [ADDR_W-1:0] a, input apipc_state_t s);
    logic [31:0] d;
    logic [1:0] r;
    d = 32'h0000_0000;
    r = RESP_OKAY;
    unique case (a)
      OFS_PRIO_01: d = packPrio(0, s.prio);
      OFS_PRIO_25: d = packPrio(1, s.prio);
      OFS_PRIO_6: d = packPrio(2, s.prio);
      OFS_STATUS: begin
        d[LEVEL_LSB +: 4] = {s.ipl3, s.status_low_byte[IPL_LSB +: 3]}; // see R7
        d[VEC_LSB +: 7] = s.vecIndex; // see R8
      end
      OFS_CTRL1: begin
        d[NESTDIS_BIT] = s.nestDis;
        d[TRAPS-1:0] = s.trapFlags;
      end
      OFS_FLAGS: d[PAIRS-1:0] = s.flags;
      OFS_FLAGCLR: d = 32'h0000_0000; // Write-only, reads zero
      OFS_ENABLE: d[PAIRS-1:0] = s.enables;
      OFS_SRL: d[7:0] = s.status_low_byte;
      OFS_TIMED_INTERRUPT_DISABLE: d[TIMED_INTERRUPT_DISABLE_W-1:0] = s.disiCount;
      default: r = RESP_SLVERR;
    endcase
    return {r, d};
  endfunction

  // ****************
  // Winner search
  // ****************
  assign curLevel = {stateReg.ipl3, stateReg.status_low_byte[IPL_LSB +: 3]};

  apipc_select #(
    .PAIRS(PAIRS),
    .TRAPS(TRAPS),
    .USER_VEC_BASE(USER_VEC_BASE)
  ) u_select (
    .userPending(stateReg.flags & stateReg.enables),
    .userPrio(stateReg.prio),
    .trapPending(stateReg.trapFlags),
    .curLevel(curLevel),
    .blockLow(stateReg.disiCount != '0),
    .winValid(winValid),
    .winLevel(winLevel),
    .winIndex(winIndex)
  );

  // ****************
  // Next state
  // ****************
  always_comb begin
    logic doWrite;
    logic [PAIRS-1:0] flagClr;
    logic [TRAPS-1:0] trapKeep;
    logic take;
    logic [3:0] newLevel;
    logic [8:0] popped;
    stateNext = stateReg;
    doWrite = 1'b0;
    flagClr = '0;
    trapKeep = '1;
    take = 1'b0;
    newLevel = 4'h0;
    popped = 9'h000;

    // Write address and data are taken independently, in either order
    if (s_axi_awvalid && stateReg.awReady) begin
      stateNext.awReady = 1'b0;
      stateNext.awGot = 1'b1;
      stateNext.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && stateReg.wReady) begin
      stateNext.wReady = 1'b0;
      stateNext.wGot = 1'b1;
      stateNext.wData = s_axi_wdata;
      stateNext.wStrb = s_axi_wstrb;
    end

    // Both halves held: commit once and answer
    if (stateReg.awGot && stateReg.wGot && !stateReg.bValid) begin
      doWrite = 1'b1;
      stateNext.awGot = 1'b0;
      stateNext.wGot = 1'b0;
      stateNext.bValid = 1'b1;
      stateNext.bResp = RESP_OKAY;
    end

    // Response taken; reopen both channels for the next write
    if (stateReg.bValid && s_axi_bready) begin
      stateNext.bValid = 1'b0;
      stateNext.awReady = 1'b1;
      stateNext.wReady = 1'b1;
    end

    // Register write effects
    if (doWrite) begin
      unique case (stateReg.awAddr)
        OFS_PRIO_01, OFS_PRIO_25, OFS_PRIO_6: begin
          for (int p = 0; p < PAIRS; p++) begin
            // Only the implemented fields under an active strobe change
            if (PAIR_REG[p] == int'(stateReg.awAddr[ADDR_W-1:2]) &&
                stateReg.wStrb[PAIR_LSB[p] / 8]) begin
              stateNext.prio[p] = stateReg.wData[PAIR_LSB[p] +: 3]; // see R3 see R4 see R5 see R6
            end
          end
        end
        OFS_CTRL1: begin
          if (stateReg.wStrb[1]) begin
            stateNext.nestDis = stateReg.wData[NESTDIS_BIT]; // see R9
          end
          if (stateReg.wStrb[0]) begin
            trapKeep = stateReg.wData[TRAPS-1:0]; // see R13
          end
        end
        OFS_FLAGCLR: begin
          if (stateReg.wStrb[0]) begin
            flagClr = stateReg.wData[PAIRS-1:0];
          end
        end
        OFS_ENABLE: begin
          if (stateReg.wStrb[0]) begin
            stateNext.enables = stateReg.wData[PAIRS-1:0];
          end
        end
        OFS_SRL: begin
          // Writing E0 here lifts the CPU to level seven
          if (stateReg.wStrb[0]) begin
            stateNext.status_low_byte = stateReg.wData[7:0]; // see R14
          end
        end
        OFS_TIMED_INTERRUPT_DISABLE: begin
          if (stateReg.wStrb[0]) begin
            stateNext.disiCount[7:0] = stateReg.wData[7:0]; // see R16
          end
          if (stateReg.wStrb[1]) begin
            stateNext.disiCount[TIMED_INTERRUPT_DISABLE_W-1:8] = stateReg.wData[TIMED_INTERRUPT_DISABLE_W-1:8];
          end
        end
        OFS_STATUS, OFS_FLAGS: begin
          // Read-only: write accepted and dropped
        end
        default: stateNext.bResp = RESP_SLVERR;
      endcase
    end else if (stateReg.disiCount != '0) begin
      // Timed disable runs down one step per cycle in which no register write commits
      stateNext.disiCount = stateReg.disiCount - 1'b1; // see R16
    end

    // Sticky flags: an event in the clearing cycle survives
    stateNext.flags = (stateReg.flags & ~flagClr) | pairDoneEvent; // see R11
    stateNext.trapFlags = (stateReg.trapFlags & trapKeep) | trapEvent; // see R13

    // Read channel: answer one cycle after the address is taken
    if (s_axi_arvalid && stateReg.arReady) begin
      {stateNext.rResp, stateNext.rData} = readWord(s_axi_araddr, stateReg);
      stateNext.rValid = 1'b1;
      stateNext.arReady = 1'b0;
    end
    if (stateReg.rValid && s_axi_rready) begin
      stateNext.rValid = 1'b0;
      stateNext.arReady = 1'b1;
    end

    // CPU takes the offer: save context, move to the source's level
    take = cpuTake && stateReg.irqRequest;
    if (take) begin
      if (stateReg.sp < SP_W'(DEPTH)) begin
        stateNext.stack[stateReg.sp] = {stateReg.ipl3, stateReg.status_low_byte};
        stateNext.sp = stateReg.sp + 1'b1;
      end
      // Nesting off: any user entry runs at seven, traps keep their own
      if (stateReg.nestDis && !stateReg.offerLevel[3]) begin
        newLevel = {1'b0, PRIO_TOP}; // see R9
      end else begin
        newLevel = stateReg.offerLevel; // see R17
      end
      stateNext.ipl3 = newLevel[3];
      stateNext.status_low_byte[IPL_LSB +: 3] = newLevel[2:0];
    end else if (cpuReturn && stateReg.sp != '0) begin
      // Return restores low byte and previous level together
      popped = stateReg.stack[stateReg.sp - 1'b1];
      stateNext.ipl3 = popped[8]; // see R12
      stateNext.status_low_byte = popped[7:0]; // see R12
      stateNext.sp = stateReg.sp - 1'b1;
    end

    // Offer is dropped for the cycle after a take so it is not taken twice
    stateNext.irqRequest = winValid && !take; // see R11 see R15 see R17
    stateNext.offerLevel = winLevel;
    stateNext.vecIndex = winValid ? winIndex : 7'h00; // see R8
    stateNext.irqLine = |(stateReg.flags & stateReg.enables);
  end

  // ****************
  // State register
  // ****************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stateReg <= '0;
      stateReg.awReady <= 1'b1;
      stateReg.wReady <= 1'b1;
      stateReg.arReady <= 1'b1;
      stateReg.status_low_byte <= SRL_RESET;
      for (int p = 0; p < PAIRS; p++) begin
        stateReg.prio[p] <= PRIO_RESET; // see R2
      end
    end else begin
      stateReg <= stateNext;
    end
  end

  // ****************
  // Outputs, all straight from the state register
  // ****************
  assign s_axi_awready = stateReg.awReady;
  assign s_axi_wready = stateReg.wReady;
  assign s_axi_bvalid = stateReg.bValid;
  assign s_axi_bresp = stateReg.bResp;
  assign s_axi_arready = stateReg.arReady;
  assign s_axi_rvalid = stateReg.rValid;
  assign s_axi_rdata = stateReg.rData;
  assign s_axi_rresp = stateReg.rResp;
  assign irqRequest = stateReg.irqRequest;
  assign irqVectorIndex = stateReg.vecIndex;
  assign irqLevel = stateReg.offerLevel;
  assign currentCpuLevel = {stateReg.ipl3, stateReg.status_low_byte[IPL_LSB +: 3]};
  assign irqLine = stateReg.irqLine;
endmodule

// *** hdl/apipc_pkg.sv ***
// Shared constants for the converter-pair interrupt priority controller
package apipc_pkg;
  // ****************
  // Sizes
  // ****************
  localparam int PAIR_COUNT = 7;               // Converter-pair done sources
  localparam int TRAP_COUNT = 4;               // Non-maskable trap sources
  localparam int ADDR_W = 8;                   // Register byte address width
  localparam int TIMED_INTERRUPT_DISABLE_W = 14;                  // Timed disable counter width
  localparam int STACK_DEPTH = 8;              // Saved-context entries

  // ****************
  // Register byte offsets
  // ****************
  localparam logic [7:0] OFS_PRIO_01 = 8'h00;  // Pairs 0 and 1 priority
  localparam logic [7:0] OFS_PRIO_25 = 8'h04;  // Pairs 2 to 5 priority
  localparam logic [7:0] OFS_PRIO_6 = 8'h08;   // Pair 6 priority
  localparam logic [7:0] OFS_STATUS = 8'h0C;   // Level and vector status
  localparam logic [7:0] OFS_CTRL1 = 8'h10;    // Interrupt control one
  localparam logic [7:0] OFS_FLAGS = 8'h14;    // Sticky source flags
  localparam logic [7:0] OFS_FLAGCLR = 8'h18;  // Write-one-to-clear flags
  localparam logic [7:0] OFS_ENABLE = 8'h1C;   // Source enables
  localparam logic [7:0] OFS_SRL = 8'h20;      // Status low byte
  localparam logic [7:0] OFS_TIMED_INTERRUPT_DISABLE = 8'h24;     // Timed disable count

  // ****************
  // Field positions and reset values
  // ****************
  localparam int PAIR_REG [PAIR_COUNT] = '{0, 0, 1, 1, 1, 1, 2};
  localparam int PAIR_LSB [PAIR_COUNT] = '{8, 12, 0, 4, 8, 12, 0};
  localparam logic [2:0] PRIO_RESET = 3'h4;    // Level four after reset
  localparam logic [2:0] PRIO_OFF = 3'h0;      // Source disabled
  localparam logic [2:0] PRIO_TOP = 3'h7;      // Highest user level
  localparam int NESTDIS_BIT = 15;             // Nesting disable in ctrl one
  localparam int LEVEL_LSB = 8;                // Status level field
  localparam int VEC_LSB = 0;                  // Status vector field
  localparam int IPL_LSB = 5;                  // Level bits in low byte
  localparam logic [7:0] SRL_RESET = 8'h00;
  localparam logic [3:0] TRAP_LEVEL_BASE = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** hdl/apipc_select.sv ***
// Priority winner selection among converter-pair sources and traps
`timescale 1ns/1ns
module apipc_select #(
  parameter int PAIRS = 7,
  parameter int TRAPS = 4,
  parameter logic [6:0] USER_VEC_BASE = 7'h20
) (
  input wire logic [PAIRS-1:0] userPending,
  input wire logic [PAIRS-1:0][2:0] userPrio,
  input wire logic [TRAPS-1:0] trapPending,
  input wire logic [3:0] curLevel,
  input wire logic blockLow,
  output logic winValid,
  output logic [3:0] winLevel,
  output logic [6:0] winIndex
);
  import apipc_pkg::*;

  // ****************
  // Winner search
  // ****************
  // The running best starts at the CPU level, so only strictly higher
  // candidates can win; ties keep the earlier (lower) source.
  always_comb begin
    winValid = 1'b0;
    winLevel = curLevel;
    winIndex = 7'h00;
    for (int p = 0; p < PAIRS; p++) begin
      // Zero disables, timed disable spares only level seven
      if (userPending[p] && userPrio[p] != PRIO_OFF &&
          !(blockLow && userPrio[p] != PRIO_TOP) &&
          {1'b0, userPrio[p]} > winLevel) begin // see R1 see R16 see R17
        winValid = 1'b1;
        winLevel = {1'b0, userPrio[p]};
        winIndex = USER_VEC_BASE + 7'(p);
      end
    end
    // Traps sit at levels eight and up and ignore every mask
    for (int t = 0; t < TRAPS; t++) begin
      if (trapPending[t] && (TRAP_LEVEL_BASE + 4'(t)) > winLevel) begin // see R15
        winValid = 1'b1;
        winLevel = TRAP_LEVEL_BASE + 4'(t);
        winIndex = 7'(t);
      end
    end
  end
endmodule

// *** testbench/apipc_top_sva.sv ***
// Port-level assertion checker for the interrupt priority controller
`timescale 1ns/1ns
module apipc_top_sva #(
  parameter logic [6:0] USER_VEC_BASE = 7'h20
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic cpuTake,
  input wire logic irqRequest,
  input wire logic [6:0] irqVectorIndex,
  input wire logic [3:0] irqLevel,
  input wire logic [3:0] currentCpuLevel
);
  // ****************
  // Common clock and reset
  // ****************
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // ****************
  // Request and acknowledge
  // ****************
  // Level must be settled, the request lags a return or level write by one cycle
  property p_req_above;
    irqRequest && $stable(currentCpuLevel) |-> irqLevel > currentCpuLevel;
  endproperty
  a_req_above: assert property (p_req_above) else $error("request not above cpu level");
  property p_take_drop;
    cpuTake && irqRequest |=> !irqRequest;
  endproperty
  a_take_drop: assert property (p_take_drop) else $error("request held after take");
  // Nesting disable may lift a user entry to seven
  property p_take_level;
    cpuTake && irqRequest |=> currentCpuLevel == $past(irqLevel) || ($past(irqLevel) < 4'h8 && currentCpuLevel == 4'h7);
  endproperty
  a_take_level: assert property (p_take_level) else $error("wrong level after take");
  property p_trap_vec;
    irqRequest && irqLevel >= 4'h8 |-> irqVectorIndex == {3'h0, irqLevel - 4'h8};
  endproperty
  a_trap_vec: assert property (p_trap_vec) else $error("trap vector mismatch");
  property p_user_vec;
    irqRequest && irqLevel < 4'h8 |-> irqVectorIndex >= USER_VEC_BASE && irqVectorIndex < USER_VEC_BASE + 7'h7;
  endproperty
  a_user_vec: assert property (p_user_vec) else $error("user vector out of range");
  property p_user_nonzero;
    irqRequest |-> irqLevel != 4'h0;
  endproperty
  a_user_nonzero: assert property (p_user_nonzero) else $error("disabled source requested");

  // ****************
  // Register bus answers
  // ****************
  property p_read_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer late");
  property p_write_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write answer mistimed");
  c_trap_take: cover property (cpuTake && irqRequest && irqLevel >= 4'h8);
  c_user_take: cover property (cpuTake && irqRequest && irqLevel < 4'h8);
  c_write: cover property (s_axi_awvalid && s_axi_awready);
endmodule
bind apipc_top apipc_top_sva #(.USER_VEC_BASE(USER_VEC_BASE)) i_sva (.mclk, .reset_n, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .cpuTake, .irqRequest, .irqVectorIndex, .irqLevel, .currentCpuLevel);

// *** testbench/apipc_cpu_model.sv ***
// Behavioural CPU core that acknowledges and returns from interrupts
`timescale 1ns/1ns
module apipc_cpu_model (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic irqRequest,
  input wire logic takeEn,
  input wire logic retReq,
  output logic cpuTake,
  output logic cpuReturn
);
  // Take only a raised request, never on two edges running
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cpuTake <= 1'b0;
      cpuReturn <= 1'b0;
    end else begin
      cpuTake <= takeEn && irqRequest && !cpuTake;
      cpuReturn <= retReq && !cpuReturn;
    end
  end
endmodule

// *** testbench/tb_top.sv ***
// Self-checking bench for the interrupt priority controller
`timescale 1ns/1ns
module tb_top;
  import apipc_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r; logic [31:0] q;} apipc_row_t;
  logic mclk, reset_n, takeEn, retReq;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb, trapEvent, irqLevel, currentCpuLevel;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [6:0] pairDoneEvent, irqVectorIndex;
  logic cpuTake, cpuReturn, irqRequest, irqLine;
  int failures, checks;
  // Map rows: address, write data, expected response, expected read back
  apipc_row_t rows [6] = '{'{8'h00, 32'hFFFFFFFF, RESP_OKAY, 32'h7700}, '{8'h04, 32'hFFFFFFFF, RESP_OKAY, 32'h7777},
    '{8'h08, 32'hFFFFFFFF, RESP_OKAY, 32'h0007}, '{8'h00, 32'h5A5A, RESP_OKAY, 32'h5200},
    '{8'h0C, 32'hFFFFFFFF, RESP_OKAY, 32'h0000}, '{8'h40, 32'h1, RESP_SLVERR, 32'h0}};

  apipc_top i_dut (.mclk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pairDoneEvent, .trapEvent,
    .cpuTake, .cpuReturn, .irqRequest, .irqVectorIndex, .irqLevel, .currentCpuLevel, .irqLine);
  apipc_cpu_model i_cpu (.mclk, .reset_n, .irqRequest, .takeEn, .retReq, .cpuTake, .cpuReturn);

  // ****************
  // Helpers
  // ****************
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic end_of_test();
    $display("Counts: %0d checks, %0d failures", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // A used-up bound ends the run instead of hanging it
  task automatic lim(input int n, input int b);
    if (n >= b) begin
      failures++;
      $display("MISMATCH wait expected done seen timeout");
      end_of_test();
    end
  endtask
  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    lim(n, 50);
    chk("bresp", s_axi_bresp, r);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    lim(n, 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a, rv, rr);
    chk("rdata", rv, e);
  endtask
  task automatic pulse(input logic [6:0] p, input logic [3:0] t);
    pairDoneEvent <= p;
    trapEvent <= t;
    tick(1);
    pairDoneEvent <= '0;
    trapEvent <= '0;
  endtask
  task automatic wait_req(input int b);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (irqRequest !== 1'b1 && n < b);
    lim(n, b);
  endtask
  task automatic take();
    int n;
    n = 0;
    takeEn <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (!(cpuTake === 1'b1 && irqRequest === 1'b1) && n < 20);
    lim(n, 20);
    takeEn <= 1'b0;
    tick(1);
  endtask
  task automatic ret();
    retReq <= 1'b1;
    tick(1);
    retReq <= 1'b0;
    tick(2);
  endtask

  // ****************
  // Main sequence
  // ****************
  initial begin
    {reset_n, takeEn, retReq, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, pairDoneEvent, trapEvent} = '0;
    s_axi_wstrb = 4'hF;
    failures = 0;
    checks = 0;
    tick(6);
    reset_n <= 1'b1;
    tick(1);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, rows[i].r);
      rd(rows[i].a, rv, rr);
      chk("rresp", rr, rows[i].r);
      if (rows[i].r == RESP_OKAY) chk("map", rv, rows[i].q);
    end
    $display("Test register map done");
    // Priority, flag clear, then enable; pair1 off, pair2 at six
    wr(8'h00, 32'h0300, RESP_OKAY);
    wr(8'h04, 32'h0006, RESP_OKAY);
    wr(8'h08, 32'h0007, RESP_OKAY);
    wr(8'h18, 32'h7F, RESP_OKAY);
    wr(8'h1C, 32'h7F, RESP_OKAY);
    pulse(7'h07, 4'h0);
    wait_req(20);
    chk("lvl", irqLevel, 4'h6);
    chk("vec", irqVectorIndex, 7'h22);
    chk("line", irqLine, 1'b1);
    rdc(8'h0C, 32'h0022);
    take();
    chk("cpu", currentCpuLevel, 4'h6);
    tick(3);
    chk("req", irqRequest, 1'b0);
    pulse(7'h40, 4'h0);
    wait_req(20);
    chk("vec", irqVectorIndex, 7'h26);
    take();
    chk("cpu", currentCpuLevel, 4'h7);
    ret();
    wait_req(20);
    chk("cpu", currentCpuLevel, 4'h6);
    chk("lvl", irqLevel, 4'h7);
    wr(8'h18, 32'h40, RESP_OKAY);
    tick(2);
    chk("req", irqRequest, 1'b0);
    ret();
    wait_req(20);
    chk("vec", irqVectorIndex, 7'h22);
    wr(8'h18, 32'h7F, RESP_OKAY);
    wr(8'h1C, 32'h0, RESP_OKAY);
    pulse(7'h08, 4'h0);
    tick(2);
    chk("line", irqLine, 1'b0);
    rdc(8'h14, 32'h08);
    wr(8'h1C, 32'h7F, RESP_OKAY);
    tick(2);
    chk("line", irqLine, 1'b1);
    wr(8'h18, 32'h7F, RESP_OKAY);
    $display("Test take and return done");
    // Every priority code on pair six, zero never requests
    for (int lv = 0; lv < 8; lv++) begin
      wr(8'h08, lv, RESP_OKAY);
      pulse(7'h40, 4'h0);
      tick(3);
      chk("req", irqRequest, lv != 0);
      if (lv != 0) chk("lvl", irqLevel, lv);
      wr(8'h18, 32'h40, RESP_OKAY);
    end
    $display("Test priority codes done");
    // Masked by E0 in the low byte, traps still get through
    wr(8'h20, 32'hE0, RESP_OKAY);
    chk("cpu", currentCpuLevel, 4'h7);
    pulse(7'h40, 4'h0);
    tick(3);
    chk("req", irqRequest, 1'b0);
    pulse(7'h00, 4'h2);
    wait_req(20);
    chk("lvl", irqLevel, 4'h9);
    take();
    chk("cpu", currentCpuLevel, 4'h9);
    rdc(8'h10, 32'h2);
    ret();
    wait_req(20);
    chk("cpu", currentCpuLevel, 4'h7);
    wr(8'h10, 32'h0, RESP_OKAY);
    tick(2);
    chk("req", irqRequest, 1'b0);
    wr(8'h20, 32'h0, RESP_OKAY);
    wait_req(20);
    chk("lvl", irqLevel, 4'h7);
    $display("Test masking and traps done");
    // Timed disable holds back six but not seven
    wr(8'h08, 32'h6, RESP_OKAY);
    wr(8'h24, 32'd60, RESP_OKAY);
    tick(2);
    chk("req", irqRequest, 1'b0);
    wr(8'h08, 32'h7, RESP_OKAY);
    wait_req(10);
    chk("lvl", irqLevel, 4'h7);
    wr(8'h08, 32'h6, RESP_OKAY);
    tick(2);
    chk("req", irqRequest, 1'b0);
    wait_req(100);
    chk("lvl", irqLevel, 4'h6);
    $display("Test timed disable done");
    wr(8'h10, 32'h8000, RESP_OKAY);
    take();
    chk("cpu", currentCpuLevel, 4'h7);
    rdc(8'h10, 32'h8000);
    ret();
    wr(8'h18, 32'h7F, RESP_OKAY);
    $display("Test nesting disable done");
    // Second reset in mid-run brings level four back
    reset_n <= 1'b0;
    tick(2);
    reset_n <= 1'b1;
    tick(1);
    rdc(8'h00, 32'h4400);
    rdc(8'h04, 32'h4444);
    rdc(8'h08, 32'h0004);
    rdc(8'h0C, 32'h0000);
    $display("Test reset done");
    end_of_test();
  end
endmodule
